// ==== hw/pmcs_sequencer.sv ====
// position mode command sequencer: command word decode, profile queue, state word
// Operation
// - running profile replaced at once when apply-now
// - defer off: stop at target, then queued
// - defer on: pass target at speed, then queued
// - 0x000F enables operation, no motion yet
// - 0x001F/0x005F queue after running positioning
// - 0x003F/0x007F modify running positioning immediately
// - halt ramps down, still operation enabled
// - unwritten profile entries keep old values
// - leaving to 0x0007 stops mode, re-enable restarts
// - mode changes only taken outside operation enabled
// - start allowed directly from switched on
// - new-target edge after completion starts next
// - mode 7 selects interpolated position mode
// - interp bits: 4 enable, 7 reset, 8 halt
// - state bit 12 shows interp mode active
// - accept flag set on edge, cleared later
// - bit 6 picks absolute or relative target
`timescale 1ns/1ps
`default_nettype none
module pmcs_sequencer
  import pmcs_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst_b,
  input  wire logic [CMD_W-1:0]    drive_command_word,
  input  wire logic [MODE_W-1:0]   operating_mode_select,
  input  wire pmcs_profile_t       profile_in,
  input  wire logic                drive_fault,
  input  wire logic                axis_at_target,
  input  wire logic                axis_stopped,
  output logic [CMD_W-1:0]         drive_state_word,
  output logic [MODE_W-1:0]        mode_active,
  output pmcs_profile_t            active_profile,
  output pmcs_motion_t             motion,
  output logic                     interp_mode_enable
);

  logic          rst_meta_reg;
  logic          rst_sync_b;
  pmcs_state_t   state_reg;
  pmcs_state_t   state_next;
  logic [CMD_W-1:0] cmd_prev_reg;
  logic [MODE_W-1:0] mode_reg;
  logic          running_reg;
  logic          queued_reg;
  logic          stopping_reg;
  logic          ack_reg;
  logic          start_reg;
  logic          blend_reg;
  logic [CMD_W-1:0] state_word_reg;
  pmcs_profile_t queued_profile;
  pmcs_profile_t new_profile;
  pmcs_profile_t active_d;
  logic          load_active;
  logic          load_queued;
  logic          new_target_rise;
  logic          fault_reset_rise;
  logic          oper_en;
  logic          oper_en_next;
  logic          ack_next;
  logic          profile_mode;
  logic          interp_mode;
  logic          halt;
  logic          accept;
  logic          adopt_queued;
  logic          finished;

  // release of reset through two flops
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_b   <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_b   <= rst_meta_reg;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      cmd_prev_reg <= '0;
    else
      cmd_prev_reg <= drive_command_word;
  end

  assign new_target_rise  = drive_command_word[CB_NEW_TARGET] & ~cmd_prev_reg[CB_NEW_TARGET];
  assign fault_reset_rise = drive_command_word[CB_FAULT_RESET] & ~cmd_prev_reg[CB_FAULT_RESET];
  assign oper_en      = (state_reg == PMCS_OPER_EN);
  assign oper_en_next = (state_next == PMCS_OPER_EN);
  assign profile_mode = (mode_reg == MODE_PROFILE_POS);
  assign interp_mode  = (mode_reg == MODE_INTERP_POS);
  assign halt         = drive_command_word[CB_HALT];

  // state machine; a control word needs bits 0..3 to walk it, and a bit 7 edge to leave fault
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      PMCS_SW_DISABLED:
        if (drive_command_word[CB_EN_VOLTAGE] && drive_command_word[CB_QUICK_STOP_N]
            && !drive_command_word[CB_SWITCH_ON])
          state_next = PMCS_READY;
      PMCS_READY:
        if (!drive_command_word[CB_EN_VOLTAGE] || !drive_command_word[CB_QUICK_STOP_N])
          state_next = PMCS_SW_DISABLED;
        else if (drive_command_word[CB_SWITCH_ON])
          state_next = PMCS_SWITCHED_ON;
      PMCS_SWITCHED_ON:
        if (!drive_command_word[CB_EN_VOLTAGE] || !drive_command_word[CB_QUICK_STOP_N])
          state_next = PMCS_SW_DISABLED;
        else if (!drive_command_word[CB_SWITCH_ON])
          state_next = PMCS_READY;
        else if (drive_command_word[CB_EN_OPER])
          state_next = PMCS_OPER_EN;
      PMCS_OPER_EN:
        if (!drive_command_word[CB_EN_VOLTAGE] || !drive_command_word[CB_QUICK_STOP_N])
          state_next = PMCS_SW_DISABLED;
        else if (!drive_command_word[CB_SWITCH_ON])
          state_next = PMCS_READY;
        else if (!drive_command_word[CB_EN_OPER])
          state_next = PMCS_SWITCHED_ON;
      PMCS_FAULT:
        if (fault_reset_rise && !drive_fault)
          state_next = PMCS_SW_DISABLED;
      default:
        state_next = PMCS_SW_DISABLED;
    endcase
    if (drive_fault)
      state_next = PMCS_FAULT;
  end

  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      state_reg <= PMCS_SW_DISABLED;
    else
      state_reg <= state_next;
  end

  // mode is latched only outside operation enabled, so a change mid-motion waits
  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      mode_reg <= MODE_RESET;
    else if (!oper_en)
      mode_reg <= operating_mode_select;
  end

  // next state, not current: a start straight from switched on keeps its edge
  assign accept = oper_en_next && profile_mode && !halt && new_target_rise;

  always_comb
  begin
    new_profile          = profile_in;
    new_profile.relative = drive_command_word[CB_RELATIVE];
  end

  assign finished     = running_reg && axis_at_target && !queued_reg;
  // defer on: switch as the target is passed; off: only once the axis stands
  // halt holds the queued target back until released
  assign adopt_queued = running_reg && queued_reg && axis_at_target && !halt
                        && (drive_command_word[CB_DEFER_SWITCH] || axis_stopped);

  assign load_active = (accept && (!running_reg || drive_command_word[CB_APPLY_NOW]))
                       || adopt_queued;
  assign load_queued = accept && running_reg && !drive_command_word[CB_APPLY_NOW];
  assign active_d    = adopt_queued ? queued_profile : new_profile;

  pmcs_profile_slot u_active_slot (
    .clock      (clock),
    .rst_sync_b (rst_sync_b),
    .load       (load_active),
    .d          (active_d),
    .q          (active_profile)
  );

  pmcs_profile_slot u_queued_slot (
    .clock      (clock),
    .rst_sync_b (rst_sync_b),
    .load       (load_queued),
    .d          (new_profile),
    .q          (queued_profile)
  );

  // motion bookkeeping; leaving operation enabled drops all of it
  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      running_reg  <= 1'b0;
      queued_reg   <= 1'b0;
      start_reg    <= 1'b0;
      blend_reg    <= 1'b0;
      stopping_reg <= 1'b0;
    end
    else if (!oper_en_next || !profile_mode)
    begin
      running_reg  <= 1'b0;
      queued_reg   <= 1'b0;
      start_reg    <= 1'b0;
      blend_reg    <= 1'b0;
      stopping_reg <= 1'b0;
    end
    else
    begin
      start_reg    <= load_active;
      blend_reg    <= adopt_queued && drive_command_word[CB_DEFER_SWITCH];
      stopping_reg <= queued_reg && !drive_command_word[CB_DEFER_SWITCH];
      if (load_queued)
        queued_reg <= 1'b1;
      else if (adopt_queued || (accept && drive_command_word[CB_APPLY_NOW]))
        queued_reg <= 1'b0;
      if (load_active)
        running_reg <= 1'b1;
      else if (finished || (halt && axis_stopped))
        running_reg <= 1'b0;
    end
  end

  // accept flag: set wins over clear in the same cycle
  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      ack_reg <= 1'b0;
    else if (accept)
      ack_reg <= 1'b1;
    else if (!drive_command_word[CB_NEW_TARGET])
      ack_reg <= 1'b0;
  end

  // flag value after this edge, so the state word shows it together with start
  assign ack_next = accept || (ack_reg && drive_command_word[CB_NEW_TARGET]);

  assign interp_mode_enable = oper_en && interp_mode
                              && drive_command_word[CB_INTERP_EN] && !halt;

  // the halt level drives the ramp-down on profile deceleration
  always_comb
  begin
    motion.start          = start_reg;
    motion.running        = running_reg;
    motion.stop_at_target = stopping_reg;
    motion.blend          = blend_reg;
    motion.halt           = oper_en && halt;
    motion.interp_enable  = interp_mode_enable;
  end

  // state word built in a flop so it never glitches towards the master
  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      state_word_reg <= STATE_WORD_RESET;
    else
    begin
      state_word_reg                    <= '0;
      state_word_reg[SB_READY]          <= (state_next == PMCS_READY) || (state_next == PMCS_SWITCHED_ON)
                                           || (state_next == PMCS_OPER_EN);
      state_word_reg[SB_SWITCHED]       <= (state_next == PMCS_SWITCHED_ON) || (state_next == PMCS_OPER_EN);
      state_word_reg[SB_OPER_EN]        <= (state_next == PMCS_OPER_EN);
      state_word_reg[SB_FAULT]          <= (state_next == PMCS_FAULT);
      state_word_reg[SB_VOLTAGE]        <= 1'b1;
      state_word_reg[SB_QUICK_STOP_N]   <= (state_next == PMCS_READY) || (state_next == PMCS_SWITCHED_ON)
                                           || (state_next == PMCS_OPER_EN);
      state_word_reg[SB_SW_DISABLED]    <= (state_next == PMCS_SW_DISABLED);
      state_word_reg[SB_TARGET_REACHED] <= axis_at_target && !running_reg;
      state_word_reg[SB_MODE_ACK]       <= interp_mode ? interp_mode_enable : ack_next;
    end
  end

  assign drive_state_word = state_word_reg;
  assign mode_active      = mode_reg;

endmodule
`default_nettype wire

// ==== hw/pmcs_pkg.sv ====
// shared constants and types of the position mode command sequencer
package pmcs_pkg;

  localparam int unsigned CMD_W  = 16;
  localparam int unsigned MODE_W = 8;
  localparam int unsigned POS_W  = 32;

  // object indices of the two words the master sees
  localparam logic [15:0] DRIVE_COMMAND_WORD_IDX = 16'h6040;
  localparam logic [15:0] DRIVE_STATE_WORD_IDX   = 16'h6041;

  // command word bit positions
  localparam int unsigned CB_SWITCH_ON   = 0;
  localparam int unsigned CB_EN_VOLTAGE  = 1;
  localparam int unsigned CB_QUICK_STOP_N = 2;
  localparam int unsigned CB_EN_OPER     = 3;
  localparam int unsigned CB_NEW_TARGET  = 4;
  localparam int unsigned CB_INTERP_EN   = 4;
  localparam int unsigned CB_APPLY_NOW   = 5;
  localparam int unsigned CB_RELATIVE    = 6;
  localparam int unsigned CB_FAULT_RESET = 7;
  localparam int unsigned CB_HALT        = 8;
  localparam int unsigned CB_DEFER_SWITCH = 9;

  // state word bit positions
  localparam int unsigned SB_READY      = 0;
  localparam int unsigned SB_SWITCHED   = 1;
  localparam int unsigned SB_OPER_EN    = 2;
  localparam int unsigned SB_FAULT      = 3;
  localparam int unsigned SB_VOLTAGE    = 4;
  localparam int unsigned SB_QUICK_STOP_N = 5;
  localparam int unsigned SB_SW_DISABLED = 6;
  localparam int unsigned SB_TARGET_REACHED = 10;
  localparam int unsigned SB_MODE_ACK   = 12;

  localparam logic [CMD_W-1:0] STATE_WORD_RESET = 16'h0000;

  // operating_mode_select values
  localparam logic [MODE_W-1:0] MODE_PROFILE_POS = 8'h01;
  localparam logic [MODE_W-1:0] MODE_INTERP_POS  = 8'h07;
  localparam logic [MODE_W-1:0] MODE_RESET       = 8'h00;

  typedef enum logic [4:0] {
    PMCS_SW_DISABLED = 5'b00001,
    PMCS_READY       = 5'b00010,
    PMCS_SWITCHED_ON = 5'b00100,
    PMCS_OPER_EN     = 5'b01000,
    PMCS_FAULT       = 5'b10000
  } pmcs_state_t;

  // one travel profile; relative marks how target is read
  typedef struct packed {
    logic [POS_W-1:0] target;
    logic [POS_W-1:0] velocity;
    logic [POS_W-1:0] accel;
    logic [POS_W-1:0] decel;
    logic             relative;
  } pmcs_profile_t;

  localparam pmcs_profile_t PROFILE_RESET = '0;

  // commands to the motion generator
  typedef struct packed {
    logic start;
    logic running;
    logic stop_at_target;
    logic blend;
    logic halt;
    logic interp_enable;
  } pmcs_motion_t;

endpackage

// ==== hw/pmcs_profile_slot.sv ====
// one stored travel profile, loaded on request
`timescale 1ns/1ps
`default_nettype none
module pmcs_profile_slot
  import pmcs_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rst_sync_b,
  input  wire logic          load,
  input  wire pmcs_profile_t d,
  output var  pmcs_profile_t q
);

  pmcs_profile_t slot_reg;

  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      slot_reg <= PROFILE_RESET;
    else if (load)
      slot_reg <= d;
  end

  assign q = slot_reg;

endmodule
`default_nettype wire

// ==== sim/pmcs_sequencer_asserts.sv ====
// concurrent checks on the command sequencer ports
`timescale 1ns/1ps
`default_nettype none
module pmcs_sequencer_asserts
  import pmcs_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst_b,
  input wire logic [CMD_W-1:0]  drive_command_word,
  input wire logic              drive_fault,
  input wire logic              axis_at_target,
  input wire logic [CMD_W-1:0]  drive_state_word,
  input wire logic [MODE_W-1:0] mode_active,
  input wire pmcs_motion_t      motion,
  input wire logic              interp_mode_enable
);
  logic [15:0] cw;
  logic [7:0]  sw;
  logic        en;
  assign cw = drive_command_word;
  assign sw = drive_state_word[7:0];
  assign en = drive_state_word[SB_OPER_EN] && !drive_fault;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  sequence s_run_ok;
    en && cw[3:0] == 4'hF && !cw[CB_HALT];
  endsequence
  sequence s_take;
    $rose(cw[CB_NEW_TARGET]) && mode_active == MODE_PROFILE_POS;
  endsequence
  a_shutdown_ready: assert property (sw == 8'h50 && cw == 16'h0006 && !drive_fault |=> sw == 8'h31)
    else $error("shutdown did not reach ready");
  a_enable_quiet: assert property (sw == 8'h33 && cw == 16'h000F && !drive_fault |=> sw == 8'h37 && !motion.start)
    else $error("enable gave wrong state or motion");
  a_direct_start: assert property (sw == 8'h33 && cw == 16'h001F && !drive_fault ##0 s_take |=> motion.start)
    else $error("start from switched on refused");
  a_next_start: assert property (s_run_ok ##0 s_take ##0 !motion.running |=> motion.start && motion.running)
    else $error("idle new target did not start");
  a_replace_now: assert property (s_run_ok ##0 s_take ##0 motion.running && cw[CB_APPLY_NOW] |=> motion.start)
    else $error("apply now did not replace profile");
  a_queue_wait: assert property (s_run_ok ##0 s_take ##0 motion.running && !cw[CB_APPLY_NOW] && !axis_at_target
    |=> !motion.start)
    else $error("queued target started early");
  a_halt_holds: assert property (en && cw[CB_HALT] && cw[3:0] == 4'hF |=> drive_state_word[SB_OPER_EN] && !motion.start)
    else $error("halt left operation enabled or started");
  a_leave_enabled: assert property (en && cw == 16'h0007 |=> drive_state_word[2:0] == 3'b011)
    else $error("0x0007 did not stop operation");
  a_mode_guard: assert property (drive_state_word[SB_OPER_EN] && $past(drive_state_word[SB_OPER_EN])
    |-> $stable(mode_active))
    else $error("mode changed while enabled");
  a_fault_entry: assert property (drive_fault && drive_state_word[SB_VOLTAGE] |=> drive_state_word[SB_FAULT])
    else $error("fault not reported");
  a_ip_enable: assert property (drive_state_word[SB_OPER_EN] && mode_active == MODE_INTERP_POS
    |-> interp_mode_enable == (cw[CB_INTERP_EN] && !cw[CB_HALT]))
    else $error("interpolation enable wrong");
endmodule
bind pmcs_sequencer pmcs_sequencer_asserts i_pmcs_sequencer_asserts (.clock(clock), .rst_b(rst_b),
  .drive_command_word(drive_command_word), .drive_fault(drive_fault), .axis_at_target(axis_at_target),
  .drive_state_word(drive_state_word), .mode_active(mode_active), .motion(motion),
  .interp_mode_enable(interp_mode_enable));
`default_nettype wire

// ==== sim/pmcs_master_model.sv ====
// fieldbus master model: presents command word and mode to the drive
`timescale 1ns/1ps
`default_nettype none
module pmcs_master_model
  import pmcs_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic [CMD_W-1:0]  cmd_req,
  input  wire logic [MODE_W-1:0] mode_req,
  input  wire logic [CMD_W-1:0]  state_word,
  output logic [CMD_W-1:0]       cmd_out,
  output logic [MODE_W-1:0]      mode_out
);
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      cmd_out <= 16'h0000;
    else
      cmd_out <= cmd_req;
  // mode held while operation enabled: a live switch is the hazard
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      mode_out <= MODE_RESET;
    else if (!state_word[SB_OPER_EN])
      mode_out <= mode_req;
endmodule
`default_nettype wire

// ==== sim/pmcs_sequencer_tb.sv ====
// self-checking bench of the position mode command sequencer
`timescale 1ns/1ps
`default_nettype none
module pmcs_sequencer_tb
  import pmcs_pkg::*;
;
  typedef struct {realtime due; logic [63:0] e; logic [63:0] m;} pmcs_note_t;
  logic          clock = 1'b0;
  logic          rst_b = 1'b0;
  logic [15:0]   cmd_req = 16'h0000;
  logic [7:0]    mode_req = MODE_PROFILE_POS;
  logic [15:0]   cmd, sw;
  logic [7:0]    mode, mode_act;
  pmcs_profile_t profile_in = PROFILE_RESET;
  pmcs_profile_t ap, p;
  pmcs_motion_t  mo;
  logic          fault = 1'b0;
  logic          at = 1'b0;
  logic          st = 1'b0;
  logic          ime;
  logic [63:0]   obs;
  logic [31:0]   tgt;
  int            seed = 76990;
  int            errors = 0;
  int            tests_run = 0;
  int            cyc = 0;
  pmcs_note_t    q[$];
  pmcs_master_model i_pmcs_master_model (.clock(clock), .rst_b(rst_b), .cmd_req(cmd_req),
    .mode_req(mode_req), .state_word(sw), .cmd_out(cmd), .mode_out(mode));
  pmcs_sequencer i_pmcs_sequencer (.clock(clock), .rst_b(rst_b), .drive_command_word(cmd),
    .operating_mode_select(mode), .profile_in(profile_in), .drive_fault(fault), .axis_at_target(at),
    .axis_stopped(st), .drive_state_word(sw), .mode_active(mode_act), .active_profile(ap),
    .motion(mo), .interp_mode_enable(ime));
  assign obs = {ap.target, ap.relative, mode_act, ime, mo, sw};
  always #12.5 clock = ~clock;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // result lands two edges after the write: model register, then design register
  task automatic step(input logic [15:0] c, input logic a, input logic s, input logic [31:0] e,
    input logic [31:0] m, input logic ct);
    q.push_back('{$realtime + 62.5, {tgt, e}, {ct ? 32'hFFFFFFFF : 32'h0, m}});
    cmd_req <= c;
    @(posedge clock);
    at <= a;
    st <= s;
    repeat (2) @(posedge clock);
  endtask
  task automatic newp();
    p = {$random(seed), $random(seed), $random(seed), $random(seed), 1'b0};
    profile_in <= p;
  endtask
  always @(negedge clock)
  begin
    cyc++;
    if (q.size() > 0 && q[0].due <= $realtime)
    begin
      tests_run++;
      if ((obs & q[0].m) !== (q[0].e & q[0].m))
      begin
        errors++;
        $display("[FAIL] t=%0t exp=%h got=%h", $time, q[0].e & q[0].m, obs & q[0].m);
      end
      void'(q.pop_front());
    end
    if (cyc == 400)
    begin
      errors++;
      stop_test();
    end
  end
  initial
  begin
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    step(16'h0000, 0, 0, 32'h00800050, 32'h7F8000FF, 0);
    step(16'h0006, 0, 0, 32'h31, 32'hFF, 0);
    step(16'h0007, 0, 0, 32'h33, 32'hFF, 0);
    step(16'h000F, 0, 0, 32'h37, 32'h2000FF, 0);
    $display("enable sequence done");
    newp();
    tgt = p.target;
    step(16'h001F, 0, 0, 32'h00301037, 32'h803010FF, 1);
    step(16'h000F, 0, 0, 32'h00100037, 32'h001010FF, 0);
    newp();
    tgt = p.target;
    step(16'h003F, 0, 0, 32'h00301037, 32'h003010FF, 1);
    step(16'h000F, 0, 0, 32'h00100037, 32'h003010FF, 0);
    newp();
    step(16'h005F, 0, 0, 32'h00100037, 32'h003000FF, 1);
    step(16'h000F, 0, 0, 32'h00180037, 32'h003800FF, 0);
    tgt = p.target;
    step(16'h000F, 1, 1, 32'h80200037, 32'h802000FF, 1);
    $display("queue and replace done");
    newp();
    tgt = p.target;
    step(16'h001F, 0, 0, 32'h00300037, 32'h003000FF, 1);
    step(16'h000F, 0, 0, 32'h37, 32'hFF, 0);
    newp();
    step(16'h021F, 0, 0, 32'h00100037, 32'h003000FF, 1);
    tgt = p.target;
    step(16'h020F, 1, 0, 32'h00340037, 32'h003400FF, 1);
    step(16'h011F, 0, 0, 32'h00020037, 32'h002200FF, 0);
    step(16'h0007, 0, 0, 32'h33, 32'hFF, 0);
    step(16'h001F, 0, 0, 32'h00300037, 32'h003000FF, 0);
    step(16'h0007, 0, 0, 32'h33, 32'hFF, 0);
    $display("halt and restart done");
    mode_req <= MODE_INTERP_POS;
    step(16'h000F, 0, 0, 32'h03800037, 32'h7F8000FF, 0);
    step(16'h001F, 0, 0, 32'h00401037, 32'h004010FF, 0);
    step(16'h011F, 0, 0, 32'h00020037, 32'h004200FF, 0);
    fault <= 1'b1;
    step(16'h011F, 0, 0, 32'h08, 32'h0F, 0);
    fault <= 1'b0;
    step(16'h0080, 0, 0, 32'h50, 32'hFF, 0);
    $display("interpolation and fault done");
    stop_test();
  end
endmodule
`default_nettype wire
